/* sensor_params.svh */
// Purpose: Shared offsets, field positions, reset values and timing counts
// Assumes: 100 MHz system clock on both ends
// Notes: Definitions only
`ifndef SENSOR_PARAMS_SVH
`define SENSOR_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 10
`define POR_INIT_NS 200000
`define POR_INIT_CYCLES ((`POR_INIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define EXIT_PAUSE_NS 1000
`define EXIT_PAUSE_CYCLES ((`EXIT_PAUSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define SCL_QUARTER_NS 625
`define SCL_QUARTER_CYCLES ((`SCL_QUARTER_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

// ****************************************
// Device register space
// ****************************************
`define CHIP_ADDR_DEFAULT 7'h39
`define ENABLE_REG 8'h80
`define ENABLE_RESET 8'h00
`define POWER_ON_BIT 0
`define COLOR_LIGHT_BIT 1
`define PROXIMITY_BIT 2
`define PATTERN_GEN_BIT 7
`define SAI_REG 8'hAB
`define SAI_BIT 4
`define RO_FIRST 8'h91
`define RO_LAST 8'h9E
`define PAIR_A_FIRST 8'h84
`define PAIR_A_LAST 8'h8B
`define PAIR_B_FIRST 8'h94
`define PAIR_B_LAST 8'h9D
`define PAIR_C_FIRST 8'hC0
`define PAIR_C_LAST 8'hC7

// ****************************************
// Host controller register port
// ****************************************
`define HOST_TARGET_REG 3'h0
`define HOST_WDATA_REG 3'h1
`define HOST_CMD_REG 3'h2
`define HOST_STATUS_REG 3'h3
`define HOST_RDATA_REG 3'h4
`define HOST_CMD_WRITE_BIT 0
`define HOST_CMD_READ_BIT 1

`endif

/* sensor_pkg.sv */
// Purpose: Types shared by both ends of the serial register port
// Assumes: Nothing
// Notes: States carry no explicit codes
package sensor_pkg;
  typedef enum logic [2:0] {OP_INIT, OP_SLEEP, OP_IDLE, OP_PAUSE, OP_ACTIVE, OP_SAI_SLEEP} op_state_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WR, S_RD} slave_state_t;
  typedef enum logic [1:0] {H_WAIT_INIT, H_IDLE, H_RUN} host_state_t;
  typedef enum logic [1:0] {I_START, I_BYTE, I_RBYTE, I_STOP} item_t;
endpackage

/* i2c_link_if.sv */
// Purpose: Two-wire link between host controller and sensor device
// Assumes: Open-drain wires with pull-ups
// Notes: Enables are active low; a released wire reads high
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
  logic host_scl_out;
  logic host_scl_oe_b;
  logic host_sda_out;
  logic host_sda_oe_b;
  logic dev_sda_out;
  logic dev_sda_oe_b;
  logic scl;
  logic sda;

  // Wired-AND of all drivers with pull-up
  assign scl = host_scl_oe_b ? 1'b1 : host_scl_out;
  assign sda = (host_sda_oe_b ? 1'b1 : host_sda_out) & (dev_sda_oe_b ? 1'b1 : dev_sda_out);

  modport host (output host_scl_out, output host_scl_oe_b, output host_sda_out, output host_sda_oe_b,
    input scl, input sda);
  modport device (output dev_sda_out, output dev_sda_oe_b, input scl, input sda);
endinterface
`default_nettype wire

/* sensor_i2c_device.sv */
// Purpose: Sensor serial register slave with power and engine sequencing
// Assumes: Link pins sampled through two flops at 100 MHz
// Notes: Register space is 256 bytes; engines post results through result port
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "sensor_params.svh"

// What this block does
// - Slave on 7-bit address, up to 400 kHz
// - Byte pointer increments after each data byte
// - Pointer survives STOP
// - Address-less read continues at pointer
// - Low-byte read latches whole 16-bit field
// - Master writes low then high byte
// - Write: START, address, register, data, STOP
// - Slave acks or nacks ninth clock
// - Read: register set, repeated START, read
// - Master nacks final read byte, then STOP
// - Nack all accesses during power-on init
// - Init ends in SLEEP; bus still served
// - Power-on bit moves SLEEP to IDLE
// - First engine start waits exit pause
// - No engine enabled returns to IDLE
// - Proximity and color run concurrently
// - Pattern generator preempts proximity, and color unless in pattern standby
// - Calibration request suspends proximity
// - Interrupt with sleep-after-interrupt enters SLEEP
// - Interrupt sleep keeps register contents
// - Clearing sleep-after-interrupt leaves that SLEEP
// - Power-on cleared clears engine enables
module sensor_i2c_device #(
  parameter int INIT_CYCLES = `POR_INIT_CYCLES,
  parameter int PAUSE_CYCLES = `EXIT_PAUSE_CYCLES,
  parameter logic [6:0] CHIP_ADDR = `CHIP_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_b,
  i2c_link_if.device link,
  input wire logic non_gesture_irq,
  input wire logic prox_cal_request,
  input wire logic pattern_standby,
  input wire logic result_we,
  input wire logic [7:0] result_addr,
  input wire logic [7:0] result_data,
  output logic init_done,
  output logic serial_core_awake,
  output logic osc_run,
  output logic color_run,
  output logic prox_run,
  output logic pattern_run,
  output sensor_pkg::op_state_t op_state
);

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic scl_m1;
  logic scl_s;
  logic scl_d;
  logic sda_m1;
  logic sda_s;
  logic sda_d;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_m1 <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m1 <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m1 <= link.scl;
      scl_s <= scl_m1;
      scl_d <= scl_s;
      sda_m1 <= link.sda;
      sda_s <= sda_m1;
      sda_d <= sda_s;
    end
  end

  wire start_seen = scl_s && scl_d && sda_d && !sda_s;
  wire stop_seen = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;

  // ****************************************
  // Register space and slave state
  // ****************************************
  sensor_pkg::slave_state_t st;
  logic [7:0] mem [0:255];
  logic [7:0] ptr;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [3:0] cnt;
  logic addr_ok;
  logic master_nack;
  logic [15:0] rd_latch;
  logic [7:0] wr_low;
  logic sda_oe_b;

  wire [7:0] ptr_next = 8'(ptr + 8'h01);
  wire ptr_is16 = (ptr >= `PAIR_A_FIRST && ptr <= `PAIR_A_LAST) ||
    (ptr >= `PAIR_B_FIRST && ptr <= `PAIR_B_LAST) || (ptr >= `PAIR_C_FIRST && ptr <= `PAIR_C_LAST);
  wire ptr_ro = ptr >= `RO_FIRST && ptr <= `RO_LAST;
  wire [7:0] rd_byte = (ptr_is16 && ptr[0]) ? rd_latch[15:8] : mem[ptr];
  wire addr_match = (shreg[7:1] == CHIP_ADDR) && init_done;
  wire [7:0] en_mask = 8'h01 << `POWER_ON_BIT;
  wire [7:0] clr_mask = (8'h01 << `PATTERN_GEN_BIT) | (8'h01 << `PROXIMITY_BIT) | (8'h01 << `COLOR_LIGHT_BIT);
  wire enable_hit = ptr == `ENABLE_REG;
  wire [7:0] enable_wdata = (shreg & en_mask) != 8'h00 ? shreg : (shreg & ~clr_mask);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= 8'h00;
      end
      st <= sensor_pkg::S_IDLE;
      ptr <= 8'h00;
      shreg <= 8'h00;
      tx <= 8'h00;
      cnt <= 4'h0;
      addr_ok <= 1'b0;
      master_nack <= 1'b0;
      rd_latch <= 16'h0000;
      wr_low <= 8'h00;
      sda_oe_b <= 1'b1;
    end else begin
      if (result_we) begin
        mem[result_addr] <= result_data;
      end
      if (start_seen) begin
        st <= sensor_pkg::S_ADDR;
        cnt <= 4'h0;
        sda_oe_b <= 1'b1;
      end else if (stop_seen) begin
        st <= sensor_pkg::S_IDLE;
        sda_oe_b <= 1'b1;
      end else if (st != sensor_pkg::S_IDLE) begin
        if (scl_rise) begin
          cnt <= 4'(cnt + 4'h1);
          if (cnt < 4'h8) begin
            shreg <= {shreg[6:0], sda_s};
          end else begin
            master_nack <= sda_s;
          end
        end else if (scl_fall) begin
          if (cnt == 4'h8) begin
            case (st)
              sensor_pkg::S_ADDR: begin
                addr_ok <= addr_match;
                sda_oe_b <= ~addr_match;
              end
              sensor_pkg::S_REG: begin
                ptr <= shreg;
                sda_oe_b <= 1'b0;
              end
              sensor_pkg::S_WR: begin
                sda_oe_b <= 1'b0;
                ptr <= ptr_next;
                if (ptr_is16 && !ptr[0]) begin
                  wr_low <= shreg;
                end else if (ptr_is16) begin
                  mem[8'(ptr - 8'h01)] <= wr_low;
                  mem[ptr] <= shreg;
                end else if (enable_hit) begin
                  mem[ptr] <= enable_wdata;
                end else if (!ptr_ro) begin
                  mem[ptr] <= shreg;
                end
              end
              default: begin
                sda_oe_b <= 1'b1;
              end
            endcase
          end else if (cnt == 4'h9) begin
            cnt <= 4'h0;
            sda_oe_b <= 1'b1;
            case (st)
              sensor_pkg::S_ADDR: begin
                if (!addr_ok) begin
                  st <= sensor_pkg::S_IDLE;
                end else if (shreg[0]) begin
                  st <= sensor_pkg::S_RD;
                  tx <= rd_byte;
                  sda_oe_b <= rd_byte[7];
                  ptr <= ptr_next;
                  if (ptr_is16 && !ptr[0]) begin
                    rd_latch <= {mem[ptr_next], mem[ptr]};
                  end
                end else begin
                  st <= sensor_pkg::S_REG;
                end
              end
              sensor_pkg::S_REG: begin
                st <= sensor_pkg::S_WR;
              end
              sensor_pkg::S_RD: begin
                if (master_nack) begin
                  st <= sensor_pkg::S_IDLE;
                end else begin
                  tx <= rd_byte;
                  sda_oe_b <= rd_byte[7];
                  ptr <= ptr_next;
                  if (ptr_is16 && !ptr[0]) begin
                    rd_latch <= {mem[ptr_next], mem[ptr]};
                  end
                end
              end
              default: begin
                st <= st;
              end
            endcase
          end else if (st == sensor_pkg::S_RD) begin
            sda_oe_b <= tx[3'(3'h7 - cnt[2:0])];
          end
        end
      end
    end
  end

  assign link.dev_sda_out = 1'b0;
  assign link.dev_sda_oe_b = sda_oe_b;
  assign serial_core_awake = st != sensor_pkg::S_IDLE;

  // ****************************************
  // Operating state sequencing
  // ****************************************
  logic [31:0] timer;
  logic first_done;

  wire power_on_bit = mem[`ENABLE_REG][`POWER_ON_BIT];
  wire color_en = mem[`ENABLE_REG][`COLOR_LIGHT_BIT];
  wire prox_en = mem[`ENABLE_REG][`PROXIMITY_BIT];
  wire pattern_en = mem[`ENABLE_REG][`PATTERN_GEN_BIT];
  wire sleep_after_interrupt = mem[`SAI_REG][`SAI_BIT];
  wire any_en = color_en || prox_en || pattern_en;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      op_state <= sensor_pkg::OP_INIT;
      timer <= 32'h0000_0000;
      first_done <= 1'b0;
    end else begin
      case (op_state)
        sensor_pkg::OP_INIT: begin
          if (timer == 32'(INIT_CYCLES - 1)) begin
            op_state <= sensor_pkg::OP_SLEEP;
            timer <= 32'h0000_0000;
          end else begin
            timer <= 32'(timer + 32'h0000_0001);
          end
        end
        sensor_pkg::OP_SLEEP: begin
          if (power_on_bit) begin
            op_state <= sensor_pkg::OP_IDLE;
          end
        end
        sensor_pkg::OP_IDLE: begin
          if (!power_on_bit) begin
            op_state <= sensor_pkg::OP_SLEEP;
          end else if (any_en && first_done) begin
            op_state <= sensor_pkg::OP_ACTIVE;
          end else if (any_en) begin
            op_state <= sensor_pkg::OP_PAUSE;
            timer <= 32'h0000_0000;
          end
        end
        sensor_pkg::OP_PAUSE: begin
          if (!power_on_bit) begin
            op_state <= sensor_pkg::OP_SLEEP;
          end else if (timer == 32'(PAUSE_CYCLES - 1)) begin
            op_state <= sensor_pkg::OP_ACTIVE;
            first_done <= 1'b1;
          end else begin
            timer <= 32'(timer + 32'h0000_0001);
          end
        end
        sensor_pkg::OP_ACTIVE: begin
          if (!power_on_bit) begin
            op_state <= sensor_pkg::OP_SLEEP;
          end else if (sleep_after_interrupt && non_gesture_irq) begin
            op_state <= sensor_pkg::OP_SAI_SLEEP;
          end else if (!any_en) begin
            op_state <= sensor_pkg::OP_IDLE;
          end
        end
        sensor_pkg::OP_SAI_SLEEP: begin
          if (!sleep_after_interrupt) begin
            op_state <= power_on_bit ? sensor_pkg::OP_IDLE : sensor_pkg::OP_SLEEP;
          end
        end
        default: begin
          op_state <= sensor_pkg::OP_INIT;
        end
      endcase
    end
  end

  wire active = op_state == sensor_pkg::OP_ACTIVE;
  assign init_done = op_state != sensor_pkg::OP_INIT;
  assign osc_run = active || op_state == sensor_pkg::OP_IDLE || op_state == sensor_pkg::OP_PAUSE ||
    pattern_run;
  assign pattern_run = pattern_en && (active || op_state == sensor_pkg::OP_SAI_SLEEP);
  assign color_run = active && color_en && (!pattern_en || pattern_standby);
  assign prox_run = active && prox_en && !pattern_en && !prox_cal_request;

endmodule
`default_nettype wire

/* sensor_i2c_host.sv */
// Purpose: Host controller issuing single-byte register writes and reads
// Assumes: Software port with read data one cycle after the strobe
// Notes: No clock stretching; SCL is a divider of the system clock
`timescale 1ns/10ps
`default_nettype none
`include "sensor_params.svh"
module sensor_i2c_host #(
  parameter int QUARTER_CYCLES = `SCL_QUARTER_CYCLES,
  parameter int INIT_CYCLES = `POR_INIT_CYCLES,
  parameter logic [6:0] CHIP_ADDR = `CHIP_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_b,
  i2c_link_if.host link,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);

  // ****************************************
  // Software registers
  // ****************************************
  sensor_pkg::host_state_t hst;
  logic [7:0] target;
  logic [7:0] data_out;
  logic [7:0] data_in;
  logic is_read;
  logic nack;
  logic [31:0] wait_cnt;

  wire busy = hst == sensor_pkg::H_RUN;
  wire ready = hst == sensor_pkg::H_IDLE;
  wire go = wr && addr == `HOST_CMD_REG && ready;
  wire [7:0] status = {5'h00, ready, nack, busy};
  wire [7:0] rd_mux = addr == `HOST_TARGET_REG ? target : addr == `HOST_WDATA_REG ? data_out :
    addr == `HOST_STATUS_REG ? status : addr == `HOST_RDATA_REG ? data_in : 8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end
  end

  // ****************************************
  // Bit sequencer
  // ****************************************
  logic sda_m1;
  logic sda_s;
  logic [2:0] idx;
  logic [3:0] bc;
  logic [1:0] q;
  logic [31:0] qcnt;
  logic scl_low;
  logic sda_low;

  wire tick = qcnt == 32'(QUARTER_CYCLES - 1);
  wire [2:0] stop_idx = is_read ? 3'h6 : 3'h4;
  wire sda_bit = sda_s;
  sensor_pkg::item_t kind;
  logic [7:0] cur_byte;

  always_comb begin
    kind = sensor_pkg::I_BYTE;
    cur_byte = {CHIP_ADDR, 1'b0};
    if (idx == 3'h0 || (is_read && idx == 3'h3)) begin
      kind = sensor_pkg::I_START;
    end else if (idx == stop_idx) begin
      kind = sensor_pkg::I_STOP;
    end else if (is_read && idx == 3'h5) begin
      kind = sensor_pkg::I_RBYTE;
    end
    if (idx == 3'h2) begin
      cur_byte = target;
    end else if (idx == 3'h3) begin
      cur_byte = data_out;
    end else if (idx == 3'h4) begin
      cur_byte = {CHIP_ADDR, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sda_m1 <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      sda_m1 <= link.sda;
      sda_s <= sda_m1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hst <= sensor_pkg::H_WAIT_INIT;
      target <= 8'h00;
      data_out <= 8'h00;
      data_in <= 8'h00;
      is_read <= 1'b0;
      nack <= 1'b0;
      wait_cnt <= 32'h0000_0000;
      idx <= 3'h0;
      bc <= 4'h0;
      q <= 2'h0;
      qcnt <= 32'h0000_0000;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      if (wr && addr == `HOST_TARGET_REG && !busy) begin
        target <= wdata;
      end
      if (wr && addr == `HOST_WDATA_REG && !busy) begin
        data_out <= wdata;
      end
      case (hst)
        sensor_pkg::H_WAIT_INIT: begin
          wait_cnt <= 32'(wait_cnt + 32'h0000_0001);
          if (wait_cnt == 32'(INIT_CYCLES - 1)) begin
            hst <= sensor_pkg::H_IDLE;
          end
        end
        sensor_pkg::H_IDLE: begin
          if (go && (wdata[`HOST_CMD_WRITE_BIT] || wdata[`HOST_CMD_READ_BIT])) begin
            hst <= sensor_pkg::H_RUN;
            is_read <= wdata[`HOST_CMD_READ_BIT] && !wdata[`HOST_CMD_WRITE_BIT];
            nack <= 1'b0;
            idx <= 3'h0;
            bc <= 4'h0;
            q <= 2'h0;
            qcnt <= 32'h0000_0000;
          end
        end
        sensor_pkg::H_RUN: begin
          qcnt <= tick ? 32'h0000_0000 : 32'(qcnt + 32'h0000_0001);
          if (tick) begin
            q <= 2'(q + 2'h1);
            case (q)
              2'h0: begin
                scl_low <= 1'b1;
                if (kind == sensor_pkg::I_START) begin
                  sda_low <= 1'b0;
                end else if (kind == sensor_pkg::I_STOP) begin
                  sda_low <= 1'b1;
                end else if (kind == sensor_pkg::I_BYTE && bc < 4'h8) begin
                  sda_low <= ~cur_byte[3'(3'h7 - bc[2:0])];
                end else begin
                  sda_low <= 1'b0;
                end
              end
              2'h1: begin
                scl_low <= 1'b0;
              end
              2'h2: begin
                if (kind == sensor_pkg::I_START) begin
                  sda_low <= 1'b1;
                end else if (kind == sensor_pkg::I_STOP) begin
                  sda_low <= 1'b0;
                end else if (kind == sensor_pkg::I_RBYTE && bc < 4'h8) begin
                  data_in <= {data_in[6:0], sda_bit};
                end else if (kind == sensor_pkg::I_BYTE && bc == 4'h8 && sda_bit) begin
                  nack <= 1'b1;
                end
              end
              default: begin
                if (kind == sensor_pkg::I_STOP) begin
                  hst <= sensor_pkg::H_IDLE;
                end else begin
                  scl_low <= 1'b1;
                  if (kind == sensor_pkg::I_START || bc == 4'h8) begin
                    bc <= 4'h0;
                    idx <= nack ? stop_idx : 3'(idx + 3'h1);
                  end else begin
                    bc <= 4'(bc + 4'h1);
                  end
                end
              end
            endcase
          end
        end
        default: begin
          hst <= sensor_pkg::H_WAIT_INIT;
        end
      endcase
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe_b = ~scl_low;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe_b = ~sda_low;

endmodule
`default_nettype wire

/* serial_register_port_power_states_sva.sv */
// Purpose: Wire-level checks on the two-wire link between host and sensor
// Assumes: One clock domain; reset asynchronous, active low
// Notes: Watches the link interface signals only
`timescale 1ns/10ps
`default_nettype none
module serial_register_port_power_states_sva #(
  parameter int INIT_CYCLES = 50,
  parameter int BIT_CYCLES = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_b,
  input wire logic dev_sda_oe_b
);
  // ****************************************
  // Helper counters
  // ****************************************
  int init_cnt;
  int low_cnt;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt <= 0;
      low_cnt <= 0;
    end else begin
      init_cnt <= (init_cnt < INIT_CYCLES) ? init_cnt + 1 : init_cnt;
      low_cnt <= dev_sda_oe_b ? 0 : low_cnt + 1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_init_quiet:
    assert property (init_cnt < INIT_CYCLES |-> dev_sda_oe_b) else $error("device drove data during init");
  a_dev_drive_edge:
    assert property ($fell(dev_sda_oe_b) |-> !scl) else $error("device pulled data while clock high");
  a_dev_release_edge:
    assert property ($rose(dev_sda_oe_b) |-> !scl) else $error("device released data while clock high");
  // Longest legal hold: address ack followed by eight zero data bits
  a_dev_hold_bound:
    assert property (low_cnt <= 9 * BIT_CYCLES) else $error("device held data low too long");
  a_scl_high_min:
    assert property ($rose(scl) |-> scl [*8]) else $error("clock high phase too short");
  a_scl_low_min:
    assert property ($fell(scl) |-> !scl [*8]) else $error("clock low phase too short");
  a_start_by_host:
    assert property ($fell(sda) && scl |-> !host_sda_oe_b) else $error("start not made by host");
  a_sda_stable_high:
    assert property (scl && $changed(sda) |-> $changed(host_sda_oe_b)) else $error("data moved under clock high");
endmodule
`default_nettype wire

/* serial_register_port_power_states_tb_top.sv */
// Purpose: Self-checking bench joining host controller and sensor device
// Assumes: Shortened init, pause and bit-quarter counts
// Notes: Software port drives the host; engine inputs drive the device
`timescale 1ns/10ps
`default_nettype none
`include "sensor_params.svh"
module serial_register_port_power_states_tb_top;
  logic clock, rst_b, wr, rd, irq, cal, standby, res_we;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, res_addr, res_data, v;
  logic init_done, awake, osc_run, color_run, prox_run, pattern_run;
  sensor_pkg::op_state_t op_state;
  int failures, cmp_count;

  i2c_link_if i2c_link_if_i ();
  // Host waits less than the device so an early access meets the init refusal
  sensor_i2c_host #(.QUARTER_CYCLES(8), .INIT_CYCLES(20)) sensor_i2c_host_i (.clock(clock), .rst_b(rst_b),
    .link(i2c_link_if_i.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  sensor_i2c_device #(.INIT_CYCLES(400), .PAUSE_CYCLES(4)) sensor_i2c_device_i (.clock(clock), .rst_b(rst_b),
    .link(i2c_link_if_i.device), .non_gesture_irq(irq), .prox_cal_request(cal), .pattern_standby(standby),
    .result_we(res_we), .result_addr(res_addr), .result_data(res_data), .init_done(init_done),
    .serial_core_awake(awake), .osc_run(osc_run), .color_run(color_run), .prox_run(prox_run),
    .pattern_run(pattern_run), .op_state(op_state));
  serial_register_port_power_states_sva #(.INIT_CYCLES(400), .BIT_CYCLES(32)) serial_register_port_power_states_sva_i (
    .clock(clock), .rst_b(rst_b), .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
    .host_sda_oe_b(i2c_link_if_i.host_sda_oe_b), .dev_sda_oe_b(i2c_link_if_i.dev_sda_oe_b));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_ready;
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      reg_rd(`HOST_STATUS_REG, s);
      n++;
    end while (s[2:0] !== 3'b100 && n < 3000);
    check(s & 8'h07, 8'h04);
  endtask
  task automatic dev_wr(input logic [7:0] r, input logic [7:0] d);
    reg_wr(`HOST_TARGET_REG, r);
    reg_wr(`HOST_WDATA_REG, d);
    reg_wr(`HOST_CMD_REG, 8'h01);
    wait_ready();
    repeat (10) @(posedge clock);
    #1;
  endtask
  task automatic dev_rd(input logic [7:0] r, output logic [7:0] d);
    reg_wr(`HOST_TARGET_REG, r);
    reg_wr(`HOST_CMD_REG, 8'h02);
    wait_ready();
    reg_rd(`HOST_RDATA_REG, d);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_init;
    #1 check(8'(op_state), 8'(sensor_pkg::OP_INIT));
    check(8'(init_done), 8'h00);
    reg_rd(`HOST_STATUS_REG, v);
    check(v & 8'h04, 8'h00);
    wait_ready();
    reg_wr(`HOST_TARGET_REG, `ENABLE_REG);
    reg_wr(`HOST_CMD_REG, 8'h01);
    repeat (500) @(posedge clock);
    reg_rd(`HOST_STATUS_REG, v);
    check(v & 8'h07, 8'h06);
    check(8'(op_state), 8'(sensor_pkg::OP_SLEEP));
    check(8'(osc_run), 8'h00);
    $display("test init done");
  endtask
  task automatic t_power;
    dev_wr(`ENABLE_REG, 8'h01);
    check(8'(op_state), 8'(sensor_pkg::OP_IDLE));
    check(8'(osc_run), 8'h01);
    dev_rd(`ENABLE_REG, v);
    check(v, 8'h01);
    $display("test power done");
  endtask
  task automatic t_engines;
    dev_wr(`ENABLE_REG, 8'h07);
    check(8'(op_state), 8'(sensor_pkg::OP_ACTIVE));
    check({6'h00, color_run, prox_run}, 8'h03);
    cal <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check(8'(prox_run), 8'h00);
    cal <= 1'b0;
    standby <= 1'b0;
    dev_wr(`ENABLE_REG, 8'h87);
    check({5'h00, pattern_run, color_run, prox_run}, 8'h04);
    standby <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check({5'h00, pattern_run, color_run, prox_run}, 8'h06);
    $display("test engines done");
  endtask
  task automatic t_latch;
    res_we <= 1'b1;
    res_addr <= 8'h94;
    res_data <= 8'h34;
    @(posedge clock);
    res_addr <= 8'h95;
    res_data <= 8'h12;
    @(posedge clock);
    res_we <= 1'b0;
    dev_rd(8'h94, v);
    check(v, 8'h34);
    res_we <= 1'b1;
    res_data <= 8'h56;
    @(posedge clock);
    res_we <= 1'b0;
    dev_rd(8'h95, v);
    check(v, 8'h12);
    dev_rd(8'h95, v);
    check(v, 8'h12);
    dev_wr(8'h84, 8'h78);
    dev_wr(8'h85, 8'h9A);
    dev_rd(8'h84, v);
    check(v, 8'h78);
    dev_rd(8'h85, v);
    check(v, 8'h9A);
    $display("test latch done");
  endtask
  task automatic t_sai;
    standby <= 1'b0;
    dev_wr(`SAI_REG, 8'h10);
    irq <= 1'b1;
    repeat (5) @(posedge clock);
    #1 check(8'(op_state), 8'(sensor_pkg::OP_SAI_SLEEP));
    check(8'(pattern_run), 8'h01);
    irq <= 1'b0;
    dev_rd(`ENABLE_REG, v);
    check(v, 8'h87);
    check(8'(op_state), 8'(sensor_pkg::OP_SAI_SLEEP));
    dev_wr(`SAI_REG, 8'h00);
    check(8'(op_state), 8'(sensor_pkg::OP_ACTIVE));
    standby <= 1'b1;
    $display("test sleep after interrupt done");
  endtask
  task automatic t_off;
    dev_wr(`ENABLE_REG, 8'h01);
    check(8'(op_state), 8'(sensor_pkg::OP_IDLE));
    check(8'(pattern_run), 8'h00);
    dev_wr(`ENABLE_REG, 8'h86);
    check(8'(osc_run), 8'h00);
    check(8'(op_state), 8'(sensor_pkg::OP_SLEEP));
    dev_rd(`ENABLE_REG, v);
    check(v, 8'h00);
    check(8'(awake), 8'h00);
    $display("test power off done");
  endtask

  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rst_b, wr, rd, irq, cal, res_we} = '0;
    standby = 1'b1;
    addr = '0;
    {wdata, res_addr, res_data} = '0;
    failures = 0;
    cmp_count = 0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    t_init();
    t_power();
    t_engines();
    t_latch();
    t_sai();
    t_off();
    test_done();
  end
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    test_done();
  end
endmodule
`default_nettype wire
